// ==== rtl/acfc_pkg.sv ====
// Purpose: Shared constants and types for the analog channel feature block
// Assumes: 16-bit register words, register numbers on 6 bits
// Notes: Clock rate figures feed the watchdog cycle count
package acfc_pkg;
    // Register numbers
    localparam logic [5:0] REG_RAW = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h06;
    localparam logic [5:0] REG_FAC_OFS = 6'h13;
    localparam logic [5:0] REG_FAC_GAIN = 6'h14;
    localparam logic [5:0] REG_UPPER = 6'h15;
    localparam logic [5:0] REG_LOWER = 6'h16;
    localparam logic [5:0] REG_CODE = 6'h1F;
    localparam logic [5:0] REG_FEATURE = 6'h20;
    localparam logic [5:0] REG_USR_OFS = 6'h21;
    localparam logic [5:0] REG_USR_GAIN = 6'h22;
    localparam logic [5:0] REG_THR_ONE = 6'h23;
    localparam logic [5:0] REG_THR_TWO = 6'h24;
    localparam logic [5:0] REG_CUTOFF = 6'h25;

    // Feature register bit positions
    localparam int FT_FILTER = 11;
    localparam int FT_THR_TWO = 10;
    localparam int FT_THR_ONE = 9;
    localparam int FT_CLAMP = 8;
    localparam int FT_TAGGED = 4;
    localparam int FT_SIGNMAG = 3;
    localparam int FT_WATCHDOG = 2;
    localparam int FT_FACTORY = 1;
    localparam int FT_USER = 0;

    // Reset values and fixed constants
    localparam logic [15:0] FEATURE_RST = 16'h0906;
    localparam logic [15:0] USR_OFS_RST = 16'h0000;
    localparam logic [15:0] USR_GAIN_RST = 16'h0400;
    localparam logic [15:0] THR_RST = 16'h0000;
    localparam logic [15:0] CUTOFF_RST = 16'h0100;
    localparam logic [15:0] CODE_RST = 16'h0000;
    localparam logic [15:0] CODE_KEY = 16'h1235;
    localparam logic [15:0] UPPER_LIMIT = 16'h0FFF;
    localparam logic [15:0] LOWER_LIMIT = 16'h0000;
    localparam logic [15:0] FAC_OFS = 16'h0000;
    localparam logic [15:0] FAC_GAIN = 16'h2000;
    localparam int GAIN_SHIFT = 10;

    // Filter cut-off codes and matching shift amounts
    localparam logic [15:0] CUT_A = 16'h0100;
    localparam logic [15:0] CUT_B = 16'h0200;
    localparam logic [15:0] CUT_C = 16'h0300;
    localparam logic [15:0] CUT_D = 16'h0400;
    localparam logic [2:0] SHIFT_A = 3'h2;
    localparam logic [2:0] SHIFT_B = 3'h3;
    localparam logic [2:0] SHIFT_C = 3'h4;
    localparam logic [2:0] SHIFT_D = 3'h5;

    // Status byte bit positions
    localparam int ST_UNDER = 0;
    localparam int ST_OVER = 1;
    localparam int ST_THR_ONE = 2;
    localparam int ST_THR_TWO = 3;
    localparam int ST_WATCHDOG = 6;

    // Tag field codes for the status-tagged format
    localparam logic [2:0] TAG_NONE = 3'h0;
    localparam logic [2:0] TAG_LOW_CURRENT = 3'h3;
    localparam logic [2:0] TAG_OVERFLOW = 3'h1;

    // Watchdog timing
    localparam int WD_TIME_MS = 100;
    localparam int CLK_MHZ = 125;
    localparam int WD_CYCLES = WD_TIME_MS * CLK_MHZ * 1000;

    typedef struct packed {
        logic write;
        logic [5:0] number;
        logic [15:0] data;
    } acfc_reg_req_t;
endpackage

// ==== rtl/acfc_iir_filter.sv ====
// Purpose: First-order low-pass filter on the measured value
// Assumes: Samples arrive as single-cycle valid pulses
// Notes: Unknown cut-off codes pass samples straight through
`timescale 1ns/1ps
module acfc_iir_filter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic enable,
    input wire logic [15:0] cutoffCode,
    // Sample in
    input wire logic sampleValid,
    input wire logic signed [15:0] sampleIn,
    // Sample out
    output logic outValid,
    output logic signed [15:0] outValue
);
    logic [2:0] shift;
    logic useFilter;
    logic signed [16:0] diff;
    logic signed [16:0] step;

    always_comb begin
        useFilter = enable;
        shift = acfc_pkg::SHIFT_A;
        case (cutoffCode)
            acfc_pkg::CUT_A: shift = acfc_pkg::SHIFT_A;
            acfc_pkg::CUT_B: shift = acfc_pkg::SHIFT_B;
            acfc_pkg::CUT_C: shift = acfc_pkg::SHIFT_C;
            acfc_pkg::CUT_D: shift = acfc_pkg::SHIFT_D;
            default: useFilter = 1'b0;
        endcase
        diff = 17'(sampleIn) - 17'(outValue);
        step = diff >>> shift;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            outValid <= 1'b0;
            outValue <= 16'sh0000;
        end else begin
            outValid <= sampleValid;
            if (sampleValid) begin
                if (useFilter) begin
                    outValue <= 16'(17'(outValue) + step);
                end else begin
                    outValue <= sampleIn;
                end
            end
        end
    end
endmodule

// ==== rtl/acfc_channel.sv ====
// Purpose: Per-channel configuration registers and value post-processing
// Assumes: Samples and coupler strobes come from logic on core_clk
// Notes: Registers are reached by register number, answer one cycle later
`timescale 1ns/1ps
// What this block does
// (R1) Feature bit 11 enables the filter; reset default one.
// (R2) Feature bit 10 enables threshold two; default zero.
// (R3) Feature bit 9 enables threshold one; default zero.
// (R4) Feature bit 8 enables range clamping; default one.
// (R5) With clamping on, out-of-range values set status and clamp to limit.
// (R6) Feature bit 4 selects status-tagged format, low three bits as status.
// (R7) Tagged format: value in bits 15..3, bit 2 always zero.
// (R8) Current variant tags: below range 11, above range 01, else 00.
// (R9) Feature bit 3 selects sign-magnitude; minus one reads 0x8001.
// (R10) Feature bit 2 enables watchdog tripping after 100 ms without data.
// (R11) Feature bit 1 zero applies factory scaling; default one.
// (R12) Feature bit 0 enables user scaling; default zero.
// (R13) User offset is added when user scaling is on.
// (R14) User gain 0x0400 means a factor of exactly one.
// (R15) Enabled thresholds set their status bits when value lies beyond.
// (R16) Cut-off codes 0x0100, 0x0200, 0x0300, 0x0400 pick a setting; others bypass filter.
// (R17) Coupler does standard scaling for tagged format via user scaling.
// (R18) User register writes need code word 0x1235 first, else ignored.
// (R19) Feature register resets to 0x0906.
// (R20) Order: filter, factory, user, clamp, thresholds, format.
module acfc_channel #(
    parameter int WD_CYCLES = acfc_pkg::WD_CYCLES,
    parameter bit CURRENT_INPUT = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register access
    input wire logic reqValid,
    input wire acfc_pkg::acfc_reg_req_t req,
    output logic reqAck,
    output logic [15:0] readData,
    // Measurement input
    input wire logic sampleValid,
    input wire logic signed [15:0] sampleData,
    // Process data
    input wire logic pdReceived,
    output logic processValid,
    output logic [15:0] processValue,
    output logic [7:0] statusByte,
    output logic watchdogTripped
);
    logic [15:0] featureConfig;
    logic [15:0] userScaleOffset;
    logic [15:0] userScaleGain;
    logic [15:0] thresholdOne;
    logic [15:0] thresholdTwo;
    logic [15:0] filterCutoffSelect;
    logic [15:0] codeWord;
    logic [15:0] rawValue;
    logic [31:0] wdCount;
    logic fmtTagged;
    logic fmtSignMag;

    logic filtValid;
    logic signed [15:0] filtValue;
    logic unlocked;
    logic userWrite;

    logic signed [31:0] facProd;
    logic signed [31:0] afterFac;
    logic signed [47:0] usrProd;
    logic signed [31:0] afterUsr;
    logic signed [15:0] clamped;
    logic overFlag;
    logic underFlag;
    logic thrOneHit;
    logic thrTwoHit;
    logic [15:0] signMagValue;
    logic [15:0] formatted;
    logic [2:0] tag;
    logic [15:0] next_readData;

    assign unlocked = (codeWord == acfc_pkg::CODE_KEY);
    assign userWrite = reqValid && req.write && unlocked; // R18

    acfc_iir_filter u_filter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(featureConfig[acfc_pkg::FT_FILTER]), // R1
        .cutoffCode(filterCutoffSelect), // R16
        .sampleValid(sampleValid),
        .sampleIn(sampleData),
        .outValid(filtValid),
        .outValue(filtValue)
    );

    // Code word register, writable at any time
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            codeWord <= acfc_pkg::CODE_RST;
        end else if (reqValid && req.write &&
                     req.number == acfc_pkg::REG_CODE) begin
            codeWord <= req.data;
        end
    end

    // User registers, accepted only while unlocked
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            featureConfig <= acfc_pkg::FEATURE_RST; // R19
            userScaleOffset <= acfc_pkg::USR_OFS_RST;
            userScaleGain <= acfc_pkg::USR_GAIN_RST; // R14
            thresholdOne <= acfc_pkg::THR_RST;
            thresholdTwo <= acfc_pkg::THR_RST;
            filterCutoffSelect <= acfc_pkg::CUTOFF_RST; // R16
        end else if (userWrite) begin // R18
            case (req.number)
                acfc_pkg::REG_FEATURE: featureConfig <= req.data;
                acfc_pkg::REG_USR_OFS: userScaleOffset <= req.data;
                acfc_pkg::REG_USR_GAIN: userScaleGain <= req.data;
                acfc_pkg::REG_THR_ONE: thresholdOne <= req.data;
                acfc_pkg::REG_THR_TWO: thresholdTwo <= req.data;
                acfc_pkg::REG_CUTOFF: filterCutoffSelect <= req.data;
                default: featureConfig <= featureConfig;
            endcase
        end
    end

    // Read mux
    always_comb begin
        case (req.number)
            acfc_pkg::REG_RAW: next_readData = rawValue;
            acfc_pkg::REG_STATUS: next_readData = {8'h00, statusByte};
            acfc_pkg::REG_FAC_OFS: next_readData = acfc_pkg::FAC_OFS;
            acfc_pkg::REG_FAC_GAIN: next_readData = acfc_pkg::FAC_GAIN;
            acfc_pkg::REG_UPPER: next_readData = acfc_pkg::UPPER_LIMIT;
            acfc_pkg::REG_LOWER: next_readData = acfc_pkg::LOWER_LIMIT;
            acfc_pkg::REG_CODE: next_readData = codeWord;
            acfc_pkg::REG_FEATURE: next_readData = featureConfig;
            acfc_pkg::REG_USR_OFS: next_readData = userScaleOffset;
            acfc_pkg::REG_USR_GAIN: next_readData = userScaleGain;
            acfc_pkg::REG_THR_ONE: next_readData = thresholdOne;
            acfc_pkg::REG_THR_TWO: next_readData = thresholdTwo;
            acfc_pkg::REG_CUTOFF: next_readData = filterCutoffSelect;
            default: next_readData = 16'h0000;
        endcase
    end

    // Answer every request one cycle later; writes return zero data
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reqAck <= 1'b0;
            readData <= 16'h0000;
        end else begin
            reqAck <= reqValid;
            if (reqValid) begin
                readData <= req.write ? 16'h0000 : next_readData;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rawValue <= 16'h0000;
        end else if (sampleValid) begin
            rawValue <= sampleData;
        end
    end

    // Processing chain after the filter
    always_comb begin
        facProd = 32'(filtValue) * 32'(signed'(acfc_pkg::FAC_GAIN));
        afterFac = 32'(filtValue);
        if (!featureConfig[acfc_pkg::FT_FACTORY]) begin // R11
            afterFac = (facProd >>> acfc_pkg::GAIN_SHIFT) +
                       32'(signed'(acfc_pkg::FAC_OFS)); // R20
        end
        usrProd = 48'(afterFac) * 48'(signed'(userScaleGain)); // R14
        afterUsr = afterFac;
        if (featureConfig[acfc_pkg::FT_USER]) begin // R12
            afterUsr = 32'(usrProd >>> acfc_pkg::GAIN_SHIFT) +
                       32'(signed'(userScaleOffset)); // R13
        end
        overFlag = afterUsr > 32'(signed'(acfc_pkg::UPPER_LIMIT));
        underFlag = afterUsr < 32'(signed'(acfc_pkg::LOWER_LIMIT));
        clamped = afterUsr[15:0];
        if (featureConfig[acfc_pkg::FT_CLAMP]) begin // R4
            if (overFlag) begin
                clamped = acfc_pkg::UPPER_LIMIT; // R5
            end else if (underFlag) begin
                clamped = acfc_pkg::LOWER_LIMIT; // R5
            end
        end
        thrOneHit = featureConfig[acfc_pkg::FT_THR_ONE] &&
                    clamped > signed'(thresholdOne); // R3 R15
        thrTwoHit = featureConfig[acfc_pkg::FT_THR_TWO] &&
                    clamped > signed'(thresholdTwo); // R2 R15
        signMagValue = clamped;
        if (featureConfig[acfc_pkg::FT_SIGNMAG] && clamped[15]) begin
            signMagValue = {1'b1, 15'(-clamped)}; // R9
        end
        if (CURRENT_INPUT && underFlag) begin
            tag = acfc_pkg::TAG_LOW_CURRENT; // R8
        end else if (overFlag || underFlag) begin
            tag = acfc_pkg::TAG_OVERFLOW; // R8
        end else begin
            tag = acfc_pkg::TAG_NONE;
        end
        formatted = signMagValue;
        if (featureConfig[acfc_pkg::FT_TAGGED]) begin // R6
            formatted = {signMagValue[15:3], tag}; // R7
        end
    end

    // Output stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            processValid <= 1'b0;
            processValue <= 16'h0000;
            fmtTagged <= 1'b0;
            fmtSignMag <= 1'b0;
            statusByte <= 8'h00;
        end else begin
            processValid <= filtValid;
            statusByte[acfc_pkg::ST_WATCHDOG] <= watchdogTripped;
            if (filtValid) begin
                processValue <= formatted;
                fmtTagged <= featureConfig[acfc_pkg::FT_TAGGED];
                fmtSignMag <= featureConfig[acfc_pkg::FT_SIGNMAG];
                statusByte[acfc_pkg::ST_OVER] <=
                    featureConfig[acfc_pkg::FT_CLAMP] && overFlag; // R5
                statusByte[acfc_pkg::ST_UNDER] <=
                    featureConfig[acfc_pkg::FT_CLAMP] && underFlag; // R5
                statusByte[acfc_pkg::ST_THR_ONE] <= thrOneHit; // R15
                statusByte[acfc_pkg::ST_THR_TWO] <= thrTwoHit; // R15
            end
        end
    end

    // Process data watchdog
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wdCount <= 32'h00000000;
            watchdogTripped <= 1'b0;
        end else if (pdReceived || !featureConfig[acfc_pkg::FT_WATCHDOG]) begin
            wdCount <= 32'h00000000;
            watchdogTripped <= 1'b0;
        end else if (wdCount < 32'(WD_CYCLES - 1)) begin
            wdCount <= wdCount + 32'h00000001;
        end else begin
            watchdogTripped <= 1'b1; // R10
        end
    end

    // Checks
    a_code_locked: assert property (@(posedge core_clk) disable iff (!rst_n)
        reqValid && req.write && req.number == acfc_pkg::REG_FEATURE &&
        !unlocked |=> $stable(featureConfig)) // R18
        else $error("feature register changed while locked");

    a_code_unlocked: assert property (@(posedge core_clk) disable iff (!rst_n)
        reqValid && req.write && req.number == acfc_pkg::REG_FEATURE &&
        unlocked |=> featureConfig == $past(req.data)) // R18
        else $error("unlocked feature write not taken");

    a_ack_timing: assert property (@(posedge core_clk) disable iff (!rst_n)
        reqValid |=> reqAck ##1 !reqAck || $past(reqValid))
        else $error("request not answered in one cycle");

    a_wd_trip: assert property (@(posedge core_clk) disable iff (!rst_n)
        featureConfig[acfc_pkg::FT_WATCHDOG] && !pdReceived &&
        wdCount == 32'(WD_CYCLES - 1) |=> watchdogTripped) // R10
        else $error("watchdog did not trip at its limit");

    a_wd_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        pdReceived |=> !watchdogTripped ##1 statusByte[6] == 1'b0) // R10
        else $error("process data did not clear watchdog");

    a_tag_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        processValid && fmtTagged |-> processValue[2] == 1'b0) // R7
        else $error("tagged format bit 2 not zero");

    a_tag_under: assert property (@(posedge core_clk) disable iff (!rst_n)
        processValid && fmtTagged && CURRENT_INPUT &&
        statusByte[acfc_pkg::ST_UNDER] |-> processValue[1:0] == 2'h3) // R8
        else $error("under-range tag wrong");

    a_clamp_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
        processValid && !fmtTagged && !fmtSignMag &&
        statusByte[acfc_pkg::ST_OVER] |->
        processValue == acfc_pkg::UPPER_LIMIT) // R5
        else $error("over-range value not clamped");

    a_signmag_neg: assert property (@(posedge core_clk) disable iff (!rst_n)
        processValid && fmtSignMag && !fmtTagged && processValue[15] |->
        processValue[14:0] != 15'h0000) // R9
        else $error("sign-magnitude negative zero");

    a_valid_pipe: assert property (@(posedge core_clk) disable iff (!rst_n)
        sampleValid |-> ##2 processValid) // R20
        else $error("processed value not two cycles after sample");

    a_clamp_lower: assert property ( // R5
        @(posedge core_clk) disable iff (!rst_n)
        processValid && !fmtTagged && !fmtSignMag &&
        statusByte[acfc_pkg::ST_UNDER] |->
        processValue == acfc_pkg::LOWER_LIMIT)
        else $error("under-range value not clamped");

    a_tag_over: assert property ( // R8
        @(posedge core_clk) disable iff (!rst_n)
        processValid && fmtTagged && statusByte[acfc_pkg::ST_OVER] |->
        processValue[1:0] == 2'h1)
        else $error("over-range tag wrong");

    a_reset_values: assert property ( // R19 R16 R18
        @(posedge core_clk)
        !rst_n |=> featureConfig == acfc_pkg::FEATURE_RST &&
        filterCutoffSelect == acfc_pkg::CUTOFF_RST && !unlocked)
        else $error("registers not at reset values");

    a_thr_status: assert property ( // R3 R15
        @(posedge core_clk) disable iff (!rst_n)
        filtValid && featureConfig[acfc_pkg::FT_THR_ONE] &&
        clamped > signed'(thresholdOne) |=>
        statusByte[acfc_pkg::ST_THR_ONE])
        else $error("threshold one hit not reported");

    a_wd_off: assert property ( // R10
        @(posedge core_clk) disable iff (!rst_n)
        !featureConfig[acfc_pkg::FT_WATCHDOG] |=> !watchdogTripped)
        else $error("watchdog tripped while disabled");

    a_user_lock: assert property ( // R18
        @(posedge core_clk) disable iff (!rst_n)
        !userWrite |=> $stable(userScaleOffset) && $stable(userScaleGain) &&
        $stable(thresholdTwo) && $stable(filterCutoffSelect))
        else $error("user register changed without unlocked write");

    c_locked_write: cover property (@(posedge core_clk) disable iff (!rst_n)
        reqValid && req.write && !unlocked);
    c_tagged_out: cover property (@(posedge core_clk) disable iff (!rst_n)
        processValid && fmtTagged);
    c_wd_trip: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(watchdogTripped));
    c_clamp_over: cover property (@(posedge core_clk) disable iff (!rst_n)
        processValid && statusByte[acfc_pkg::ST_OVER]);
    c_signmag_neg: cover property (@(posedge core_clk) disable iff (!rst_n)
        processValid && fmtSignMag && processValue[15]);
endmodule

// ==== test/acfc_coupler_model.sv ====
// Purpose: Coupler side model issuing register requests and process data
// Assumes: Requests are taken on the rising edge while the strobe is high
// Notes: Released request lines show inverted number and data, with write held low
`timescale 1ns/1ps
module acfc_coupler_model (
    // Clock
    input wire logic core_clk,
    // Register requests
    output logic reqValid,
    output acfc_pkg::acfc_reg_req_t req,
    input wire logic reqAck,
    input wire logic [15:0] readData,
    // Process data
    output logic pdReceived
);
    initial begin
        reqValid = 1'b0;
        req = '0;
        pdReceived = 1'b0;
    end

    // One-cycle strobe; the answer stands from the taking edge and is read half a cycle later
    task automatic access(input logic wr, input logic [5:0] num,
        input logic [15:0] dat, output logic ack, output logic [15:0] rd);
        @(negedge core_clk);
        reqValid = 1'b1;
        req = '{write: wr, number: num, data: dat};
        @(negedge core_clk);
        ack = reqAck;
        rd = readData;
        reqValid = 1'b0;
        req = '{write: 1'b0, number: ~num, data: ~dat};
    endtask

    // Unlock with the code word before every user register write
    task automatic write_user(input logic [5:0] num, input logic [15:0] dat);
        logic a;
        logic [15:0] r;
        access(1'b1, 6'h1F, 16'h1235, a, r);
        access(1'b1, num, dat, a, r);
    endtask

    task automatic pd_pulse();
        @(negedge core_clk);
        pdReceived = 1'b1;
        @(negedge core_clk);
        pdReceived = 1'b0;
    endtask
endmodule

// ==== test/analog_channel_feature_config_test.sv ====
// Purpose: Self-checking bench for the channel post-processing block
// Assumes: Inputs change at the falling edge, outputs settle by then
// Notes: Watchdog span shortened so its trip is seen in a short run
`timescale 1ns/1ps
module analog_channel_feature_config_test;
    localparam int WD_SHORT = 50;
    localparam logic [15:0] CUTS [5] = '{16'h0100, 16'h0200, 16'h0300,
        16'h0400, 16'h0500};
    localparam logic [15:0] FILT_OUT [5] = '{16'h0100, 16'h0080, 16'h0040,
        16'h0020, 16'h0400};

    logic core_clk;
    logic rst_n;
    logic reqValid;
    acfc_pkg::acfc_reg_req_t req;
    logic reqAck;
    logic [15:0] readData;
    logic sampleValid;
    logic signed [15:0] sampleData;
    logic pdReceived;
    logic processValid;
    logic [15:0] processValue;
    logic [7:0] statusByte;
    logic watchdogTripped;
    int n_errors = 0;
    int check_count = 0;

    acfc_channel #(.WD_CYCLES(WD_SHORT), .CURRENT_INPUT(1'b1)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid),
        .req(req), .reqAck(reqAck), .readData(readData),
        .sampleValid(sampleValid), .sampleData(sampleData),
        .pdReceived(pdReceived), .processValid(processValid),
        .processValue(processValue), .statusByte(statusByte),
        .watchdogTripped(watchdogTripped)
    );

    acfc_coupler_model u_cpl (
        .core_clk(core_clk), .reqValid(reqValid), .req(req),
        .reqAck(reqAck), .readData(readData), .pdReceived(pdReceived)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic complete_run();
        if (n_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
    endtask

    task automatic rd_chk(input logic [5:0] num, input logic [15:0] exp);
        logic a;
        logic [15:0] r;
        u_cpl.access(1'b0, num, 16'h0000, a, r);
        chk({15'h0000, a}, 16'h0001);
        chk(r, exp);
    endtask

    // One sample in, result two edges later; status bits 3..0 compared
    task automatic samp(input logic [15:0] x, input logic [15:0] ev,
        input logic [3:0] es);
        @(negedge core_clk);
        sampleValid = 1'b1;
        sampleData = x;
        @(negedge core_clk);
        sampleValid = 1'b0;
        sampleData = ~x;
        @(negedge core_clk);
        chk({15'h0000, processValid}, 16'h0001);
        chk(processValue, ev);
        chk({12'h000, statusByte[3:0]}, {12'h000, es});
    endtask

    // Fresh filter state per code, so the first output is x >>> k, or x for code 0x0500
    task automatic t_filter();
        for (int i = 0; i < 5; i++) begin
            do_reset();
            if (i != 0) begin
                u_cpl.write_user(6'h25, CUTS[i]);
            end
            samp(16'h0400, FILT_OUT[i], 4'h0);
            if (i == 0) begin
                samp(16'h0400, 16'h01C0, 4'h0);
            end
        end
        // Filter off: the stored state must not leak into the output
        u_cpl.write_user(6'h25, 16'h0100);
        u_cpl.write_user(6'h20, 16'h0106);
        samp(16'h0200, 16'h0200, 4'h0);
    endtask

    task automatic t_regs();
        do_reset();
        rd_chk(6'h20, 16'h0906);
        rd_chk(6'h21, 16'h0000);
        rd_chk(6'h22, 16'h0400);
        rd_chk(6'h23, 16'h0000);
        rd_chk(6'h24, 16'h0000);
        rd_chk(6'h25, 16'h0100);
        rd_chk(6'h15, 16'h0FFF);
        rd_chk(6'h16, 16'h0000);
        rd_chk(6'h13, 16'h0000);
        rd_chk(6'h14, 16'h2000);
        rd_chk(6'h2F, 16'h0000);
    endtask

    task automatic t_lock();
        logic a;
        logic [15:0] r;
        u_cpl.access(1'b1, 6'h20, 16'h0001, a, r);
        rd_chk(6'h20, 16'h0906);
        rd_chk(6'h1F, 16'h0000);
        u_cpl.write_user(6'h20, 16'h0001);
        rd_chk(6'h20, 16'h0001);
        u_cpl.access(1'b1, 6'h1F, 16'h0000, a, r);
        u_cpl.access(1'b1, 6'h20, 16'h0906, a, r);
        rd_chk(6'h20, 16'h0001);
    endtask

    task automatic t_clamp();
        u_cpl.write_user(6'h20, 16'h0102);
        samp(16'h1234, 16'h0FFF, 4'h2);
        rd_chk(6'h00, 16'h1234);
        rd_chk(6'h06, 16'h0002);
        samp(16'hFFFB, 16'h0000, 4'h1);
        samp(16'h0123, 16'h0123, 4'h0);
        u_cpl.write_user(6'h20, 16'h0002);
        samp(16'h1234, 16'h1234, 4'h0);
    endtask

    task automatic t_scale();
        u_cpl.write_user(6'h20, 16'h0000);
        samp(16'h0010, 16'h0080, 4'h0);
        u_cpl.write_user(6'h21, 16'h0005);
        u_cpl.write_user(6'h20, 16'h0002);
        samp(16'h0100, 16'h0100, 4'h0);
        u_cpl.write_user(6'h20, 16'h0003);
        samp(16'h0100, 16'h0105, 4'h0);
        u_cpl.write_user(6'h21, 16'h0001);
        u_cpl.write_user(6'h22, 16'h0800);
        u_cpl.write_user(6'h20, 16'h0001);
        samp(16'h0010, 16'h0101, 4'h0);
    endtask

    task automatic t_sign();
        u_cpl.write_user(6'h20, 16'h000A);
        samp(16'hFFFF, 16'h8001, 4'h0);
        samp(16'h0005, 16'h0005, 4'h0);
    endtask

    task automatic t_thresh();
        u_cpl.write_user(6'h23, 16'h0100);
        u_cpl.write_user(6'h24, 16'h0200);
        u_cpl.write_user(6'h20, 16'h0602);
        samp(16'h0150, 16'h0150, 4'h4);
        samp(16'h0250, 16'h0250, 4'hC);
        u_cpl.write_user(6'h20, 16'h0202);
        samp(16'h0250, 16'h0250, 4'h4);
    endtask

    // Unit values written to the user registers, user scaling left off (bit 0 zero), before tagging
    task automatic t_tagged();
        u_cpl.write_user(6'h21, 16'h0000);
        u_cpl.write_user(6'h22, 16'h0400);
        u_cpl.write_user(6'h20, 16'h0112);
        samp(16'h0123, 16'h0120, 4'h0);
        samp(16'hFFF8, 16'h0003, 4'h1);
        samp(16'h1238, 16'h0FF9, 4'h2);
    endtask

    task automatic t_wdog();
        do_reset();
        u_cpl.pd_pulse();
        repeat (40) @(negedge core_clk);
        chk({15'h0000, watchdogTripped}, 16'h0000);
        repeat (20) @(negedge core_clk);
        chk({15'h0000, watchdogTripped}, 16'h0001);
        chk({15'h0000, statusByte[6]}, 16'h0001);
        u_cpl.pd_pulse();
        repeat (2) @(negedge core_clk);
        chk({15'h0000, watchdogTripped}, 16'h0000);
        u_cpl.write_user(6'h20, 16'h0902);
        repeat (80) @(negedge core_clk);
        chk({15'h0000, watchdogTripped}, 16'h0000);
    endtask

    initial begin
        rst_n = 1'b0;
        sampleValid = 1'b0;
        sampleData = 16'sh0000;
        t_filter();
        t_regs();
        t_lock();
        t_clamp();
        t_scale();
        t_sign();
        t_thresh();
        t_tagged();
        t_wdog();
        complete_run();
    end

    // Whole run is a few hundred cycles; this span means a hang
    initial begin
        #400000;
        n_errors++;
        complete_run();
    end
endmodule
